//--- logic/sas_pkg.sv
// Purpose : Shared constants and carriers for the converter sequencer
// Assumes : APB with 32-bit data, one register per aligned word
// Notes   : Offsets are byte addresses
package sas_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONFIG  = 8'h04;
  localparam logic [7:0] OFF_RES_HI  = 8'h08;
  localparam logic [7:0] OFF_RES_LO  = 8'h0c;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTL_ENABLE = 7;
  localparam int CTL_DTRACK = 6;
  localparam int CTL_DONE   = 5;
  localparam int CTL_BUSY   = 4;
  localparam int CTL_SRC_LO = 0;

  // ****************************************************************
  // Config register fields and reset
  // ****************************************************************
  localparam int CFG_DIV_LO = 3;
  localparam int CFG_LJUST  = 2;
  localparam int CFG_EIGHT  = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'hf9;

  // ****************************************************************
  // Start source encodings
  // ****************************************************************
  localparam logic [2:0] SRC_SOFT = 3'h0;
  localparam logic [2:0] SRC_TMR0 = 3'h1;
  localparam logic [2:0] SRC_TMR2 = 3'h2;
  localparam logic [2:0] SRC_TMR1 = 3'h3;
  localparam logic [2:0] SRC_TMR3 = 3'h5;

  // ****************************************************************
  // Timing in SAR clocks
  // ****************************************************************
  localparam logic [4:0] CONV_CLK_10 = 5'hd;  // 13 clocks
  localparam logic [4:0] CONV_CLK_8  = 5'hb;  // 11 clocks
  localparam logic [4:0] TRACK_CLK   = 5'h3;

  // Timer overflow carrier
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2_lo_ovf;
    logic t2_hi_ovf;
    logic t2_split;
    logic t3_lo_ovf;
    logic t3_hi_ovf;
    logic t3_split;
  } sas_timer_t;

  // Converter analog handshake carrier
  typedef struct packed {
    logic       power_up;
    logic       track;
    logic       convert;
    logic       eight_bit;
  } sas_analog_t;

endpackage : sas_pkg

//--- logic/sas_clk_div.sv
// Purpose : SAR clock enable divider
// Assumes : Divide ratio is ratio field plus one
// Notes   : Emits one-cycle pulses, held cleared while stopped
`timescale 1ns/1ps
module sas_clk_div #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic [W-1:0] ratio,
  output logic              tick
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Next count
  always_comb begin
    if (!run || cnt_q >= ratio) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = run && (cnt_q >= ratio);

  a_tick_ratio : assert property (@(posedge pclk) disable iff (!presetn)
    tick && ratio != '0 |=> !tick || ratio == '0)
    else $error("tick without full count");

endmodule : sas_clk_div

//--- logic/sas_sequencer.sv
// Purpose : Start, track and conversion sequencing of a 10-bit SAR converter
// Assumes : APB slave, 10 MHz pclk; sar_code valid when conversion ends
// Notes   : External start pin passes two flip-flops before use
//
// What this block does
// - Converts only while enable bit set
// - Result bytes load at every conversion end
// - Right 0x03FF, left 0xFFC0 full scale
// - Unused result bits read zero
// - Eight-bit mode fills high byte only
// - Eight-bit takes two fewer SAR clocks
// - SAR clock divided from system clock
// - Six selectable conversion start sources
// - Source codes 000..011 and 101 internal, 100, 110, 111 external
// - Busy reads one during conversion
// - Busy falling at conversion end sets done, interrupt request
// - Timer 2/3 byte overflow by mode
// - Delayed track adds three SAR clocks
// - No delay converts immediately on start
// - Internal sources track when idle
// - External source tracking follows pin, select
// - Eight-bit ends clock 14 or 11
// - 13 or 11 SAR clocks per conversion
// - Divider field equals ratio minus one
// - Eight-bit mode low byte reads zero
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module sas_sequencer (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire sas_pkg::sas_timer_t timers,
  input  wire logic                external_start_input,
  input  wire logic [9:0]          sar_code,
  output sas_pkg::sas_analog_t     analog,
  output logic                     conversion_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_CONV  = 3'b100
  } sas_state_t;

  sas_state_t  st_q, st_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [7:0]  hi_q, hi_d;
  logic [7:0]  lo_q, lo_d;
  logic [31:0] rdata_q, rdata_d;
  logic        pin_s1_q, pin_s2_q, pin_old_q;
  logic        sar_tick;
  logic        start_ev;
  logic        conv_end;
  logic        wr_acc, rd_acc, addr_ok;
  logic [2:0]  src;
  logic        eight, enable, dtrack;

  assign src    = ctl_q[sas_pkg::CTL_SRC_LO +: 3];
  assign enable = ctl_q[sas_pkg::CTL_ENABLE];
  assign dtrack = ctl_q[sas_pkg::CTL_DTRACK];
  assign eight  = cfg_q[sas_pkg::CFG_EIGHT];

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q  <= 1'b0;
      pin_s2_q  <= 1'b0;
      pin_old_q <= 1'b0;
    end else begin
      pin_s1_q  <= external_start_input;
      pin_s2_q  <= pin_s1_q;
      pin_old_q <= pin_s2_q;
    end
  end

  // ****************************************************************
  // SAR clock divider
  // ****************************************************************
  sas_clk_div #(.W(5)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enable),
    .ratio   (cfg_q[sas_pkg::CFG_DIV_LO +: 5]),
    .tick    (sar_tick)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign addr_ok = paddr == sas_pkg::OFF_CONTROL || paddr == sas_pkg::OFF_CONFIG ||
                   paddr == sas_pkg::OFF_RES_HI  || paddr == sas_pkg::OFF_RES_LO;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = rdata_q;

  // ****************************************************************
  // Start source selection
  // ****************************************************************
  always_comb begin
    start_ev = 1'b0;
    if (st_q == ST_IDLE && enable) begin
      unique case (src)
        sas_pkg::SRC_SOFT: start_ev = wr_acc && paddr == sas_pkg::OFF_CONTROL &&
                                      pwdata[sas_pkg::CTL_BUSY];
        sas_pkg::SRC_TMR0: start_ev = timers.t0_ovf;
        sas_pkg::SRC_TMR1: start_ev = timers.t1_ovf;
        sas_pkg::SRC_TMR2: start_ev = timers.t2_split ? timers.t2_lo_ovf
                                                      : timers.t2_hi_ovf;
        sas_pkg::SRC_TMR3: start_ev = timers.t3_split ? timers.t3_lo_ovf
                                                      : timers.t3_hi_ovf;
        default:           start_ev = pin_s2_q && !pin_old_q;
      endcase
    end
  end

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    conv_end = 1'b0;
    if (!enable) begin
      st_d  = ST_IDLE;
      cnt_d = '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          cnt_d = '0;
          if (start_ev) begin
            st_d = dtrack ? ST_DELAY : ST_CONV;
          end
        end
        ST_DELAY: begin
          if (sar_tick) begin
            cnt_d = cnt_q + 5'h1;
            if (cnt_q + 5'h1 == sas_pkg::TRACK_CLK) begin
              st_d  = ST_CONV;
              cnt_d = '0;
            end
          end
        end
        ST_CONV: begin
          if (sar_tick) begin
            cnt_d = cnt_q + 5'h1;
            if (cnt_q + 5'h1 == (eight ? sas_pkg::CONV_CLK_8
                                       : sas_pkg::CONV_CLK_10)) begin
              st_d     = ST_IDLE;
              cnt_d    = '0;
              conv_end = 1'b1;
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers next values
  // ****************************************************************
  always_comb begin
    ctl_d   = ctl_q;
    cfg_d   = cfg_q;
    hi_d    = hi_q;
    lo_d    = lo_q;
    rdata_d = rdata_q;
    if (wr_acc && paddr == sas_pkg::OFF_CONTROL) begin
      ctl_d = {pwdata[7:6], ctl_q[5], ctl_q[4], pwdata[3:0]};
      if (!pwdata[sas_pkg::CTL_DONE]) begin
        ctl_d[sas_pkg::CTL_DONE] = 1'b0;
      end
    end
    if (wr_acc && paddr == sas_pkg::OFF_CONFIG) begin
      cfg_d = {pwdata[7:1], cfg_q[0]};
    end
    // Busy mirrors conversion in progress
    ctl_d[sas_pkg::CTL_BUSY] = (st_d != ST_IDLE);
    if (conv_end) begin
      ctl_d[sas_pkg::CTL_DONE] = 1'b1;
      if (eight) begin
        hi_d = sar_code[9:2];
        lo_d = 8'h00;
      end else if (cfg_q[sas_pkg::CFG_LJUST]) begin
        hi_d = sar_code[9:2];
        lo_d = {sar_code[1:0], 6'h00};
      end else begin
        hi_d = {6'h00, sar_code[9:8]};
        lo_d = sar_code[7:0];
      end
    end
    if (rd_acc) begin
      unique case (paddr)
        sas_pkg::OFF_CONTROL: rdata_d = {24'h000000, ctl_q};
        sas_pkg::OFF_CONFIG:  rdata_d = {24'h000000, cfg_q};
        sas_pkg::OFF_RES_HI:  rdata_d = {24'h000000, hi_q};
        sas_pkg::OFF_RES_LO:  rdata_d = {24'h000000, lo_q};
        default:              rdata_d = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= '0;
      ctl_q   <= sas_pkg::CTL_RESET;
      cfg_q   <= sas_pkg::CFG_RESET;
      hi_q    <= 8'h00;
      lo_q    <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      ctl_q   <= ctl_d;
      cfg_q   <= cfg_d;
      hi_q    <= hi_d;
      lo_q    <= lo_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Analog controls
  // ****************************************************************
  always_comb begin
    analog.power_up  = enable;
    analog.convert   = (st_q == ST_CONV);
    analog.eight_bit = eight;
    if (src[2] && src != sas_pkg::SRC_TMR3) begin
      analog.track = enable && st_q != ST_CONV &&
                     (dtrack || !pin_s2_q);
    end else begin
      analog.track = enable && st_q != ST_CONV;
    end
  end

  assign conversion_irq = ctl_q[sas_pkg::CTL_DONE];

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_conv_ends;
    ##1 (st_q == ST_IDLE);
  endsequence

  a_busy_state : assert property (@(posedge pclk) disable iff (!presetn)
    ctl_q[sas_pkg::CTL_BUSY] == (st_q != ST_IDLE))
    else $error("busy does not match state");
  a_done_on_fall : assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ctl_q[sas_pkg::CTL_BUSY]) && enable |-> ctl_q[sas_pkg::CTL_DONE])
    else $error("done not set at busy fall");
  a_off_no_conv : assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> st_q == ST_IDLE)
    else $error("conversion while disabled");
  a_eight_lo_zero : assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && eight |=> lo_q == 8'h00 && hi_q == $past(sar_code[9:2]))
    else $error("eight-bit result misplaced");
  a_right_pad : assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && !eight && !cfg_q[2] |=> hi_q[7:2] == 6'h00)
    else $error("right justify pad not zero");
  a_left_fmt : assert property (@(posedge pclk) disable iff (!presetn)
    conv_end && !eight && cfg_q[2] |=> lo_q[5:0] == 6'h00)
    else $error("left justify pad not zero");
  a_no_delay : assert property (@(posedge pclk) disable iff (!presetn)
    start_ev && !dtrack |=> st_q == ST_CONV)
    else $error("conversion did not start at once");
  a_delay_first : assert property (@(posedge pclk) disable iff (!presetn)
    start_ev && dtrack |=> st_q == ST_DELAY)
    else $error("delayed track skipped");
  a_conv_count : assert property (@(posedge pclk) disable iff (!presetn)
    conv_end |-> cnt_q == (eight ? 5'h0a : 5'h0c) ##0 s_conv_ends)
    else $error("wrong conversion length");

  // Internal sources track while idle, done stands until cleared
  a_idle_track : assert property (@(posedge pclk) disable iff (!presetn)
    enable && st_q == ST_IDLE && (!src[2] || src == sas_pkg::SRC_TMR3) |-> analog.track)
    else $error("internal source not tracking");
  a_done_holds : assert property (@(posedge pclk) disable iff (!presetn)
    ctl_q[sas_pkg::CTL_DONE] && !(wr_acc && paddr == sas_pkg::OFF_CONTROL)
    |=> ctl_q[sas_pkg::CTL_DONE])
    else $error("done flag lost");

endmodule : sas_sequencer

//--- test/sas_far_model.sv
// Purpose : Timers and analog SAR stand-in at the far side of the sequencer
// Assumes : Overflow pulses last one pclk cycle
// Notes   : Code pins carry junk that toggles whenever no conversion runs
`timescale 1ns/1ps
module sas_far_model (
  input  wire logic                 pclk,
  input  wire logic                 fire,
  input  wire logic [2:0]           which,
  input  wire logic                 split2,
  input  wire logic                 split3,
  input  wire logic [9:0]           code,
  input  wire sas_pkg::sas_analog_t analog,
  output sas_pkg::sas_timer_t       timers,
  output logic      [9:0]           sar_code
);
  logic [9:0] junk_q = 10'h155;

  // Junk pattern, flips every cycle
  always_ff @(posedge pclk) junk_q <= ~junk_q;

  // Code valid only while converting
  assign sar_code = analog.convert ? code : junk_q;

  // One overflow pulse chosen by the bench
  always_comb begin
    timers           = '0;
    timers.t2_split  = split2;
    timers.t3_split  = split3;
    timers.t0_ovf    = fire && which == 3'h0;
    timers.t1_ovf    = fire && which == 3'h1;
    timers.t2_lo_ovf = fire && which == 3'h2;
    timers.t2_hi_ovf = fire && which == 3'h3;
    timers.t3_lo_ovf = fire && which == 3'h4;
    timers.t3_hi_ovf = fire && which == 3'h5;
  end
endmodule : sas_far_model

//--- test/sas_sequencer_test.sv
// Purpose : Self-checking bench for the converter sequencer
// Assumes : Zero-wait APB slave, divider 0 gives one SAR tick per pclk
// Notes   : Table rows first, then hand-written corner cases
`timescale 1ns/1ps
module sas_sequencer_test;
  typedef struct {
    logic [2:0] src; logic dt; logic lj; logic eb; logic [4:0] div; logic [2:0] trig;
    logic s2; logic s3; logic [9:0] code; logic [7:0] hi; logic [7:0] lo; int n;
  } sas_row_t;

  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                 ext, fire, s2, s3, conversion_irq;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, ctl, r;
  logic [9:0]           sar_code, code;
  logic [2:0]           which;
  logic                 e;
  sas_pkg::sas_timer_t  timers;
  sas_pkg::sas_analog_t analog;
  int                   n_errors, check_count, n;
  sas_row_t             rw;
  sas_row_t rows[9] = '{
    '{3'h0, 0, 0, 0, 5'h0, 3'h0, 0, 0, 10'h3ff, 8'h03, 8'hff, 13},
    '{3'h0, 0, 1, 0, 5'h0, 3'h0, 0, 0, 10'h3ff, 8'hff, 8'hc0, 13},
    '{3'h1, 1, 0, 1, 5'h0, 3'h0, 0, 0, 10'h3ff, 8'hff, 8'h00, 14},
    '{3'h2, 1, 0, 0, 5'h2, 3'h3, 0, 0, 10'h200, 8'h02, 8'h00, 16},
    '{3'h3, 0, 1, 1, 5'h0, 3'h1, 0, 0, 10'h155, 8'h55, 8'h00, 11},
    '{3'h5, 0, 1, 0, 5'h0, 3'h4, 0, 1, 10'h100, 8'h40, 8'h00, 13},
    '{3'h4, 0, 0, 0, 5'h0, 3'h0, 0, 0, 10'h2a5, 8'h02, 8'ha5, 0},
    '{3'h6, 0, 1, 0, 5'h0, 3'h0, 0, 0, 10'h001, 8'h00, 8'h40, 0},
    '{3'h7, 1, 0, 1, 5'h0, 3'h0, 0, 0, 10'h3fc, 8'hff, 8'h00, 0}};

  sas_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timers(timers), .external_start_input(ext), .sar_code(sar_code),
    .analog(analog), .conversion_irq(conversion_irq));

  sas_far_model far (.pclk(pclk), .fire(fire), .which(which), .split2(s2), .split3(s3),
    .code(code), .analog(analog), .timers(timers), .sar_code(sar_code));

  // ****************************************************************
  // Clock and watchdog
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #500000;
    n_errors++;
    finish_test();
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 50) check(32'h0, 32'h1);
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd_chk

  task automatic wait_done(output int cnt);
    cnt = 0;
    do begin @(posedge pclk); #1; cnt++; end while (conversion_irq !== 1'b1 && cnt < 300);
    check({31'h0, conversion_irq}, 32'h1);
  endtask : wait_done

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ext = 1'b0; fire = 1'b0; which = 3'h0; s2 = 1'b0; s3 = 1'b0;
    code = 10'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(sas_pkg::OFF_CONTROL, 32'h00);
    rd_chk(sas_pkg::OFF_CONFIG, 32'hf9);
    rd_chk(sas_pkg::OFF_RES_HI, 32'h00);
    rd_chk(sas_pkg::OFF_RES_LO, 32'h00);
    for (int i = 0; i < 9; i++) begin
      rw = rows[i];
      s2 <= rw.s2; s3 <= rw.s3; code <= rw.code;
      wr(sas_pkg::OFF_CONFIG, {24'h0, rw.div, rw.lj, rw.eb, 1'b1});
      check({31'h0, analog.eight_bit}, {31'h0, rw.eb});
      ctl = {24'h0, 1'b1, rw.dt, 3'h0, rw.src};
      wr(sas_pkg::OFF_CONTROL, ctl);
      check({31'h0, analog.track}, 32'h1);
      if (rw.src == 3'h0) wr(sas_pkg::OFF_CONTROL, ctl | 32'h10);
      else if (rw.src[2] && rw.src != 3'h5) ext <= 1'b1;
      else begin
        ext <= rw.src[2];
        fire <= 1'b1; which <= rw.trig;
        @(posedge pclk);
        fire <= 1'b0;
      end
      wait_done(n);
      if (rw.src == 3'h0) n++;
      check({31'h0, analog.track}, {31'h0, !(rw.src[2] && rw.src != 3'h5 && !rw.dt)});
      if (rw.n != 0) check(n >= rw.n * (rw.div + 1) - rw.div && n <= rw.n * (rw.div + 1),
                           32'h1);
      ext <= 1'b0;
      rd_chk(sas_pkg::OFF_RES_HI, {24'h0, rw.hi});
      rd_chk(sas_pkg::OFF_RES_LO, {24'h0, rw.lo});
      rd_chk(sas_pkg::OFF_CONTROL, ctl | 32'h20);
      wr(sas_pkg::OFF_CONTROL, 32'h0);
      $display("row %0d finished", i);
    end
    // Disabled converter ignores a software start
    wr(sas_pkg::OFF_CONFIG, 32'h01);
    wr(sas_pkg::OFF_CONTROL, 32'h10);
    repeat (30) @(posedge pclk);
    check({31'h0, conversion_irq}, 32'h0);
    check({31'h0, analog.power_up}, 32'h0);
    $display("disabled test finished");
    // Busy mid-run, restart ignored
    wr(sas_pkg::OFF_CONTROL, 32'h80);
    wr(sas_pkg::OFF_CONTROL, 32'h90);
    rd_chk(sas_pkg::OFF_CONTROL, 32'h90);
    check({31'h0, analog.convert}, 32'h1);
    wr(sas_pkg::OFF_CONTROL, 32'h90);
    wait_done(n);
    check(n, 32'h6);
    wr(sas_pkg::OFF_CONTROL, 32'h0);
    $display("busy test finished");
    // Disable aborts a running conversion
    wr(sas_pkg::OFF_CONTROL, 32'h80);
    wr(sas_pkg::OFF_CONTROL, 32'h90);
    repeat (4) @(posedge pclk);
    check({31'h0, analog.convert}, 32'h1);
    wr(sas_pkg::OFF_CONTROL, 32'h0);
    repeat (20) @(posedge pclk);
    check({31'h0, conversion_irq}, 32'h0);
    $display("abort test finished");
    // Reset in mid conversion restores control and config registers
    wr(sas_pkg::OFF_CONTROL, 32'h80);
    wr(sas_pkg::OFF_CONTROL, 32'h90);
    repeat (3) @(posedge pclk);
    check({31'h0, analog.convert}, 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    check({31'h0, analog.convert}, 32'h0);
    presetn <= 1'b1;
    rd_chk(sas_pkg::OFF_CONTROL, 32'h00);
    rd_chk(sas_pkg::OFF_CONFIG, 32'hf9);
    check({31'h0, conversion_irq}, 32'h0);
    $display("reset test finished");
    // Timer 2 in 8-bit mode ignores its high byte overflow
    s2 <= 1'b1;
    wr(sas_pkg::OFF_CONTROL, 32'h82);
    fire <= 1'b1; which <= 3'h3;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (20) @(posedge pclk);
    rd_chk(sas_pkg::OFF_CONTROL, 32'h82);
    $display("split timer test finished");
    // Unmapped address
    apb(1'b0, 8'h10, 32'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("unmapped test finished");
    finish_test();
  end
endmodule : sas_sequencer_test
